/* pmx_io_mux.v */
// Pin mux and MAC pad control with an AXI4-Lite register slave.
// Assumes one 50 MHz clock; clock sources and pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "pmx_io_mux_regs.vh"
module pmx_io_mux #(
    parameter ADDR_W = 16,
    parameter NSRC   = 16
) (
    input  wire              i_clk,
    input  wire              i_rst_n,
    input  wire [ADDR_W-1:0] i_awaddr,
    input  wire              i_awvalid,
    output wire              o_awready,
    input  wire [31:0]       i_wdata,
    input  wire [3:0]        i_wstrb,
    input  wire              i_wvalid,
    output wire              o_wready,
    output wire [1:0]        o_bresp,
    output wire              o_bvalid,
    input  wire              i_bready,
    input  wire [ADDR_W-1:0] i_araddr,
    input  wire              i_arvalid,
    output wire              o_arready,
    output wire [31:0]       o_rdata,
    output wire [1:0]        o_rresp,
    output wire              o_rvalid,
    input  wire              i_rready,
    input  wire [NSRC-1:0]   i_clk_src,
    input  wire              i_receive_bit3_strap_value_pin,
    input  wire              i_ind1_daisy_strap_pin,
    input  wire              i_ind1_pin,
    input  wire [7:0]        i_func,
    input  wire              i_indicator1_func,
    output reg               o_ind0_out,
    output reg               o_clkout_pin,
    output reg               o_ind1_out,
    output reg               o_ind1_oe,
    output reg               o_mac_tx_error,
    output reg               o_rx_pull_up,
    output reg               o_rx_pull_dn,
    output reg               o_tx_pull_up,
    output reg               o_tx_pull_dn,
    output reg  [4:0]        o_rx_imp,
    output reg  [4:0]        o_tx_imp
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Register decode, shared by the write and the read path.
    function [2:0] reg_hit;
        input [11:0] idx;
        begin
            reg_hit = 3'h0;
            case (idx)
                `PMX_IDX_IND0:   reg_hit = 3'h1;
                `PMX_IDX_CLKPIN: reg_hit = 3'h2;
                `PMX_IDX_PAD:    reg_hit = 3'h3;
                `PMX_IDX_STRAP:  reg_hit = 3'h4;
                default:         reg_hit = 3'h0;
            endcase
        end
    endfunction
    // Function select for a pin: code 000 is the pin's own indicator and
    // code 001 the clock path; the rest come from i_func.
    function fsel;
        input [2:0] sel;
        input       clk_val;
        input       own;
        input [7:0] f;
        begin
            if (sel == `PMX_SEL_IND1) begin
                fsel = own;
            end else if (sel == `PMX_SEL_CLKMUX) begin
                fsel = clk_val;
            end else begin
                fsel = f[sel];
            end
        end
    endfunction
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    localparam NSYNC = NSRC + 3;
    reg [NSYNC-1:0] sync1_q;
    reg [NSYNC-1:0] sync2_q;
    wire [NSRC-1:0] src_s  = sync2_q[NSRC-1:0];
    wire            d3_s   = sync2_q[NSRC];
    wire            dsy_s  = sync2_q[NSRC+1];
    wire            pin1_s = sync2_q[NSRC+2];
    // Two flops per asynchronous input; only the second is read.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= {NSYNC{1'b0}};
            sync2_q <= {NSYNC{1'b0}};
        end else begin
            sync1_q <= {i_ind1_pin, i_ind1_daisy_strap_pin,
                        i_receive_bit3_strap_value_pin, i_clk_src};
            sync2_q <= sync1_q;
        end
    end
    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    reg [1:0] wait_q;
    reg       strap_done_q;
    reg       strap_d3_q;
    reg       strap_dsy_q;
    wire      cap_now = !strap_done_q && (wait_q == `PMX_STRAP_WAIT);
    // Straps are taken once the synchroniser has filled after release,
    // so the strap flops never load the synchroniser's reset value.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_q       <= 2'h0;
            strap_done_q <= 1'b0;
            strap_d3_q   <= 1'b0;
            strap_dsy_q  <= 1'b0;
        end else if (!strap_done_q) begin
            wait_q <= wait_q + 2'h1;
            if (cap_now) begin
                strap_done_q <= 1'b1;
                strap_d3_q   <= d3_s;
                strap_dsy_q  <= dsy_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    reg        aw_ok_q;
    reg        w_ok_q;
    reg [11:0] aw_idx_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    reg [15:0] ind0_q;
    reg [15:0] clkp_q;
    reg [15:0] pad_q;
    assign o_awready = !aw_ok_q && !bvalid_q;
    assign o_wready  = !w_ok_q && !bvalid_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    wire        do_wr = aw_ok_q && w_ok_q && !bvalid_q;
    wire [2:0]  w_hit = reg_hit(aw_idx_q);
    wire [15:0] bmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    // Address and data are taken in either order; the write lands and
    // the response rises one edge after both are held.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_ok_q  <= 1'b0;
            w_ok_q   <= 1'b0;
            aw_idx_q <= 12'h000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= `PMX_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_ok_q  <= 1'b1;
                aw_idx_q <= i_awaddr[13:2];
            end
            if (i_wvalid && o_wready) begin
                w_ok_q  <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_wr) begin
                aw_ok_q  <= 1'b0;
                w_ok_q   <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (w_hit == 3'h0) ? `PMX_RESP_SLVERR
                                            : `PMX_RESP_OKAY;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    wire [15:0] wm_ind0 = bmask & `PMX_MSK_IND0;
    wire [15:0] wm_clkp = bmask & `PMX_MSK_CLKPIN;
    wire [15:0] wm_pad  = bmask & `PMX_MSK_PAD;

    // Clock pin selector is loaded from the strap at capture time.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ind0_q <= `PMX_RST_IND0;
            clkp_q <= `PMX_RST_CLKPIN;
            pad_q  <= `PMX_RST_PAD;
        end else begin
            if (do_wr && w_hit == 3'h1) begin
                ind0_q <= (ind0_q & ~wm_ind0) | (wdata_q[15:0] & wm_ind0);
            end
            if (cap_now) begin
                clkp_q[`PMX_F_SEL] <= d3_s ? `PMX_SEL_STRAP1
                                           : `PMX_SEL_STRAP0;
            end else if (do_wr && w_hit == 3'h2) begin
                clkp_q <= (clkp_q & ~wm_clkp) | (wdata_q[15:0] & wm_clkp);
            end
            if (do_wr && w_hit == 3'h3) begin
                pad_q <= (pad_q & ~wm_pad) | (wdata_q[15:0] & wm_pad);
            end
        end
    end
    // The daisy strap overrides whatever software wrote to the selector.
    wire [2:0]  clk_sel = strap_dsy_q ? 3'h0 : clkp_q[`PMX_F_SEL];
    wire [15:0] clkp_rd = {clkp_q[15:3], clk_sel};
    wire [15:0] strap_rd = {13'h0000, strap_done_q, strap_dsy_q,
                            strap_d3_q};
    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    reg        rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0]  rresp_q;
    wire [2:0] r_hit = reg_hit(i_araddr[13:2]);
    assign o_arready = !rvalid_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;
    // Data is registered at the address edge; upper half reads zero.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `PMX_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `PMX_RESP_OKAY;
            case (r_hit)
                3'h1:    rdata_q <= {16'h0000, ind0_q};
                3'h2:    rdata_q <= {16'h0000, clkp_rd};
                3'h3:    rdata_q <= {16'h0000, pad_q};
                3'h4:    rdata_q <= {16'h0000, strap_rd};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `PMX_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Clock source mux, divider and inverter
    // ------------------------------------------------------------------
    // Sources are sampled at 50 MHz, so fast clocks alias; this path is
    // an observation aid, not a clean clock forward.
    wire [3:0] src = clkp_q[`PMX_F_SRC];
    reg        pick;
    always @* begin
        pick = 1'b0;
        case (src)
            `PMX_SRC_NONE:    pick = 1'b0;
            `PMX_SRC_DLL_ALT: pick = src_s[`PMX_SRC_DLL];
            default:          pick = src_s[src];
        endcase
    end
    reg pick_prev_q;
    reg half_q;
    // The halved clock toggles on each rising edge of the picked source.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pick_prev_q <= 1'b0;
            half_q      <= 1'b0;
        end else begin
            pick_prev_q <= pick;
            if (pick && !pick_prev_q) begin
                half_q <= ~half_q;
            end
        end
    end

    wire clk_path = (clkp_q[`PMX_B_DIV2] ? half_q : pick)
                    ^ clkp_q[`PMX_B_INV];
    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    wire txer_mode = clkp_q[`PMX_B_TXER];
    // All pin and pad outputs are registered to keep them glitch free.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ind0_out     <= 1'b0;
            o_clkout_pin   <= 1'b0;
            o_ind1_out     <= 1'b0;
            o_ind1_oe      <= 1'b0;
            o_mac_tx_error <= 1'b0;
            o_rx_pull_up   <= 1'b0;
            o_rx_pull_dn   <= 1'b0;
            o_tx_pull_up   <= 1'b0;
            o_tx_pull_dn   <= 1'b0;
            o_rx_imp       <= 5'h00;
            o_tx_imp       <= 5'h00;
        end else begin
            o_ind0_out   <= fsel(ind0_q[`PMX_F_SEL], pick,
                                 i_func[0], i_func);
            o_clkout_pin <= fsel(clk_sel, clk_path,
                                 i_indicator1_func, i_func);
            o_ind1_out     <= txer_mode ? 1'b0 : i_indicator1_func;
            o_ind1_oe      <= !txer_mode;
            o_mac_tx_error <= txer_mode & pin1_s;
            o_rx_pull_up   <= pad_q[`PMX_B_RX_FORCE] &&
                              pad_q[`PMX_F_RX_PULL] == `PMX_PULL_UP;
            o_rx_pull_dn   <= pad_q[`PMX_B_RX_FORCE] &&
                              pad_q[`PMX_F_RX_PULL] == `PMX_PULL_DN;
            o_tx_pull_up   <= pad_q[`PMX_B_TX_FORCE] &&
                              pad_q[`PMX_F_TX_PULL] == `PMX_PULL_UP;
            o_tx_pull_dn   <= pad_q[`PMX_B_TX_FORCE] &&
                              pad_q[`PMX_F_TX_PULL] == `PMX_PULL_DN;
            o_rx_imp       <= pad_q[`PMX_F_RX_IMP];
            o_tx_imp       <= pad_q[`PMX_F_TX_IMP];
        end
    end
endmodule // pmx_io_mux
`default_nettype wire

/* pmx_io_mux_bench.sv */
// Self-checking bench for the pin mux block over AXI4-Lite.
// Assumes pmx_io_mux and its register header; 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "pmx_io_mux_regs.vh"
module pmx_io_mux_bench;
logic        i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid;
logic        i_rready, i_receive_bit3_strap_value_pin, i_ind1_daisy_strap_pin;
logic        i_ind1_pin, i_indicator1_func;
logic [15:0] i_awaddr, i_araddr, i_clk_src;
logic [31:0] i_wdata;
logic [3:0]  i_wstrb;
logic [7:0]  i_func;
wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ind0_out;
wire         o_clkout_pin, o_ind1_out, o_ind1_oe, o_mac_tx_error;
wire         o_rx_pull_up, o_rx_pull_dn, o_tx_pull_up, o_tx_pull_dn;
wire [1:0]   o_bresp, o_rresp;
wire [31:0]  o_rdata;
wire [4:0]   o_rx_imp, o_tx_imp;
int          n_errors, n_compared;
pmx_io_mux u_pmx_io_mux (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_clk_src, .i_receive_bit3_strap_value_pin, .i_ind1_daisy_strap_pin,
    .i_ind1_pin, .i_func, .i_indicator1_func, .o_ind0_out, .o_clkout_pin,
    .o_ind1_out, .o_ind1_oe, .o_mac_tx_error, .o_rx_pull_up, .o_rx_pull_dn,
    .o_tx_pull_up, .o_tx_pull_dn, .o_rx_imp, .o_tx_imp);
// ---------------------------------------------------------------
// Shared tasks
// ---------------------------------------------------------------
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
        n_errors++;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
endtask
task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
// Handshakes are sampled at the falling edge, so no edge race exists.
task automatic axw(input [11:0] x, input [15:0] d, output [1:0] r);
    logic [3:0] h;
    int         t;
    @(posedge i_clk);
    i_awaddr <= {2'b00, x, 2'b00};
    i_wdata <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    for (t = 0; t < 60; t++) begin
        @(negedge i_clk);
        h = {i_awvalid && o_awready, i_wvalid && o_wready,
             o_bvalid && i_bready, o_bvalid};
        if (h[1]) r = o_bresp;
        @(posedge i_clk);
        if (h[3]) i_awvalid <= 1'b0;
        if (h[2]) i_wvalid <= 1'b0;
        if (h[1]) break;
        if (h[0]) i_bready <= 1'b1;
    end
    i_bready <= 1'b0;
endtask
task automatic axr(input [11:0] x, output [31:0] d, output [1:0] r);
    logic [2:0] h;
    int         t;
    @(posedge i_clk);
    i_araddr <= {2'b00, x, 2'b00};
    i_arvalid <= 1'b1;
    for (t = 0; t < 60; t++) begin
        @(negedge i_clk);
        h = {i_arvalid && o_arready, o_rvalid && i_rready, o_rvalid};
        if (h[1]) d = o_rdata;
        if (h[1]) r = o_rresp;
        @(posedge i_clk);
        if (h[2]) i_arvalid <= 1'b0;
        if (h[1]) break;
        if (h[0]) i_rready <= 1'b1;
    end
    i_rready <= 1'b0;
endtask
// Four edges cover the two sync stages and the output register.
task automatic sett;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
endtask
// ---------------------------------------------------------------
// Scenarios
// ---------------------------------------------------------------
task automatic t_rst(input logic d3, input logic dz, input [2:0] s);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge i_clk);
    i_receive_bit3_strap_value_pin <= d3;
    i_ind1_daisy_strap_pin <= dz;
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    axr(`PMX_IDX_CLKPIN, d, r);
    chk(d, {29'h0, s});
    axr(`PMX_IDX_STRAP, d, r);
    chk(d, {29'h0, 1'b1, dz, d3});
    axr(`PMX_IDX_PAD, d, r);
    chk(d, 32'h00000000);
    axw(`PMX_IDX_CLKPIN, 16'h0005, r);
    axr(`PMX_IDX_CLKPIN, d, r);
    chk(d, dz ? 32'h0 : 32'h5);
endtask
// Each selector code: the chosen source high, then every i_func bit and clock source flipped.
task automatic t_sel(input [11:0] x);
    int         k, h;
    logic [1:0] r;
    for (k = 0; k < 8; k++) begin
        axw(x, k[15:0], r);
        for (h = 1; h >= 0; h--) begin
            @(posedge i_clk);
            i_func <= h ? 8'h01 << k : ~(8'h01 << k);
            i_indicator1_func <= h && k == 0;
            i_clk_src <= ((k == 1) == h) ? 16'hFFFF : 16'h0000;
            sett;
            chk({31'h0, x == `PMX_IDX_IND0 ? o_ind0_out : o_clkout_pin},
                h);
        end
    end
endtask
task automatic tog(input [15:0] v, input int e);
    logic [1:0] r;
    logic       p;
    int         i, n;
    axw(`PMX_IDX_CLKPIN, v, r);
    n = 0;
    for (i = 0; i < 40; i++) begin
        @(posedge i_clk);
        i_clk_src <= {15'h0000, i[1]};
        @(negedge i_clk);
        if (i > 7 && o_clkout_pin !== p) n++;
        p = o_clkout_pin;
    end
    chk(n, e);
endtask
task automatic t_src;
    int         s, v;
    logic [1:0] r;
    for (v = 0; v < 2; v++) for (s = 0; s < 16; s++) begin
        axw(`PMX_IDX_CLKPIN, {8'h00, s[3:0], v[0], 3'h1}, r);
        @(posedge i_clk);
        i_clk_src <= 16'h0001 << (s == 15 ? 14 : s);
        sett;
        chk({31'h0, o_clkout_pin}, {31'h0, (s != 13) ^ v[0]});
        @(posedge i_clk);
        i_clk_src <= ~(16'h0001 << (s == 15 ? 14 : s));
        sett;
        chk({31'h0, o_clkout_pin}, {31'h0, v[0]});
    end
    tog(16'h0101, 8);
    tog(16'h0001, 16);
    axw(`PMX_IDX_CLKPIN, 16'h010A, r);
    @(posedge i_clk);
    i_func <= 8'h04;
    sett;
    chk({31'h0, o_clkout_pin}, 32'h1);
endtask
task automatic t_txer;
    logic [31:0] d;
    logic [1:0]  r;
    int          h;
    axw(`PMX_IDX_CLKPIN, 16'h8001, r);
    for (h = 0; h < 2; h++) begin
        @(posedge i_clk);
        i_ind1_pin <= h;
        i_indicator1_func <= 1'b1;
        sett;
        chk({29'h0, o_mac_tx_error, o_ind1_oe, o_ind1_out},
            {29'h0, h[0], 2'b00});
    end
    axw(`PMX_IDX_CLKPIN, 16'hFFFF, r);
    axr(`PMX_IDX_CLKPIN, d, r);
    chk(d, 32'h000081FF);
    axw(`PMX_IDX_CLKPIN, 16'h0001, r);
    sett;
    chk({29'h0, o_mac_tx_error, o_ind1_oe, o_ind1_out}, 32'h3);
endtask
task automatic t_pad;
    logic [15:0] pv [5] = '{16'h6555, 16'hB400, 16'hFFFF, 16'h4C00, 16'h2800};
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    for (i = 0; i < 5; i++) begin
        v = pv[i];
        axw(`PMX_IDX_PAD, v, r);
        chk(r, `PMX_RESP_OKAY);
        sett;
        chk({18'h0, o_rx_pull_up, o_rx_pull_dn, o_tx_pull_up, o_tx_pull_dn,
             o_rx_imp, o_tx_imp}, {18'h0, v[13] && v[15:14] == 2'h1,
             v[13] && v[15:14] == 2'h2, v[10] && v[12:11] == 2'h1,
             v[10] && v[12:11] == 2'h2, v[9:5], v[4:0]});
        axr(`PMX_IDX_PAD, d, r);
        chk(d, {16'h0, v});
    end
    // A low-byte strobe must leave the upper byte of the register alone.
    i_wstrb <= 4'h1;
    axw(`PMX_IDX_PAD, 16'hA5C3, r);
    i_wstrb <= 4'hF;
    axr(`PMX_IDX_PAD, d, r);
    chk(d, {16'h0, v[15:8], 8'hC3});
endtask
task automatic t_bad;
    logic [31:0] d;
    logic [1:0]  r;
    axw(12'h7FF, 16'h1234, r);
    chk(r, `PMX_RESP_SLVERR);
    axr(12'h7FF, d, r);
    chk({d[29:0], r}, {30'h0, `PMX_RESP_SLVERR});
endtask
// ---------------------------------------------------------------
// Clock, main sequence and watchdog
// ---------------------------------------------------------------
initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
end
// Inputs are defined at time zero; straps change only under reset.
initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= 5'h00;
    {i_receive_bit3_strap_value_pin, i_ind1_daisy_strap_pin, i_ind1_pin} <= 3'h0;
    {i_rst_n, i_indicator1_func, i_func, i_clk_src} <= 26'h0;
    {i_awaddr, i_araddr, i_wdata} <= 64'h0;
    i_wstrb <= 4'hF;
    t_rst(1'b0, 1'b0, 3'h1);
    t_sel(`PMX_IDX_IND0);
    t_sel(`PMX_IDX_CLKPIN);
    t_src;
    t_txer;
    t_pad;
    t_bad;
    t_rst(1'b1, 1'b1, 3'h0);
    t_rst(1'b1, 1'b0, 3'h0);
    test_done;
end
// A hang counts as a mismatch and ends through the same closing task.
initial begin
    repeat (30000) @(posedge i_clk);
    n_errors++;
    test_done;
end
endmodule // pmx_io_mux_bench
`default_nettype wire

/* pmx_io_mux_props.sv */
// Concurrent checks on the pin mux register slave and pin outputs.
// Assumes it is bound into pmx_io_mux; one clock domain only.
`timescale 1ns/10ps
`default_nettype none
module pmx_io_mux_props (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic        o_mac_tx_error,
    input wire logic        o_ind1_oe,
    input wire logic        o_ind1_out,
    input wire logic        o_rx_pull_up,
    input wire logic        o_rx_pull_dn,
    input wire logic        o_tx_pull_up,
    input wire logic        o_tx_pull_dn
);
// ---------------------------------------------------------------
// Bus and pin properties
// ---------------------------------------------------------------
// Reset masks everything, as the slave answers nothing while held.
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
sequence s_aw_w; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
sequence s_ar; i_arvalid && o_arready; endsequence
property p_wr_ans; s_aw_w |=> !o_bvalid ##1 o_bvalid; endproperty
property p_rd_ans; s_ar |=> o_rvalid; endproperty
property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
endproperty
property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
endproperty
property p_b_busy; o_bvalid |-> !o_awready && !o_wready; endproperty
property p_r_busy; o_rvalid |-> !o_arready; endproperty
property p_upper; o_rvalid |-> o_rdata[31:16] == 16'h0000; endproperty
property p_txer; o_mac_tx_error |-> !o_ind1_oe; endproperty
property p_ind1; !o_ind1_oe |-> !o_ind1_out; endproperty
property p_rxpull; !(o_rx_pull_up && o_rx_pull_dn); endproperty
property p_txpull; !(o_tx_pull_up && o_tx_pull_dn); endproperty
a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
a_upper: assert property (p_upper) else $error("upper read half not zero");
a_txer: assert property (p_txer)
    else $error("pin 1 driven in error input mode");
a_ind1: assert property (p_ind1)
    else $error("pin 1 value while undriven");
a_rxpull: assert property (p_rxpull)
    else $error("receive pull both ways");
a_txpull: assert property (p_txpull)
    else $error("transmit pull both ways");
endmodule // pmx_io_mux_props
bind pmx_io_mux pmx_io_mux_props u_props (.i_clk, .i_rst_n, .i_awvalid,
    .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_mac_tx_error,
    .o_ind1_oe, .o_ind1_out, .o_rx_pull_up, .o_rx_pull_dn, .o_tx_pull_up,
    .o_tx_pull_dn);
`default_nettype wire

/* pmx_io_mux_regs.vh */
// Register indices, field positions and reset values of the pin mux block.
// Assumes an includer that uses these names; no logic lives here.
`ifndef PMX_IO_MUX_REGS_VH
`define PMX_IO_MUX_REGS_VH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PMX_IDX_IND0      12'h452
`define PMX_IDX_CLKPIN    12'h453
`define PMX_IDX_PAD       12'h456
`define PMX_IDX_STRAP     12'h460
// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define PMX_RST_IND0      16'h0000
`define PMX_RST_CLKPIN    16'h0001
`define PMX_RST_PAD       16'h0000
`define PMX_MSK_IND0      16'h0007
`define PMX_MSK_CLKPIN    16'h81FF
`define PMX_MSK_PAD       16'hFFFF
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMX_B_TXER        15
`define PMX_B_DIV2        8
`define PMX_F_SRC         7:4
`define PMX_B_INV         3
`define PMX_F_SEL         2:0
`define PMX_F_RX_PULL     15:14
`define PMX_B_RX_FORCE    13
`define PMX_F_TX_PULL     12:11
`define PMX_B_TX_FORCE    10
`define PMX_F_RX_IMP      9:5
`define PMX_F_TX_IMP      4:0
// ----------------------------------------------------------------------
// Codes and timing
// ----------------------------------------------------------------------
`define PMX_SEL_IND1      3'h0
`define PMX_SEL_CLKMUX    3'h1
`define PMX_SEL_STRAP1    3'h0
`define PMX_SEL_STRAP0    3'h1
`define PMX_SRC_NONE      4'hD
`define PMX_SRC_DLL_ALT   4'hF
`define PMX_SRC_DLL       4'hE
`define PMX_PULL_UP       2'h1
`define PMX_PULL_DN       2'h2
`define PMX_STRAP_WAIT    2'h2
`define PMX_RESP_OKAY     2'h0
`define PMX_RESP_SLVERR   2'h2
`endif
